/* File: tnlc_line_coder.sv */
// media-side line coder: nrz bits in and out, pulse coding on the line pins
// assumes a 50 MHz clock and an external hybrid or rs-485 transceiver
//
// Notes on behaviour
// - hybrid coding only at the 2.5 Mbps rate
// - hybrid one: two 100ns low pulses, first then second
// - hybrid zero: both drives stay high
// - hybrid receive: positive pulse means one
// - receive window tolerates 100ns shift per 400ns bit
// - backplane first drive open-drain or push-pull by bit
// - first drive defaults to open-drain after reset
// - backplane one: single 200ns low pulse on first
// - backplane receive: low pulse means one
// - backplane second drive carries bit clock
// - backplane first drive pulses only while transceiver enabled; hybrid pulses leave it inactive
// - reset holds drives and enable inactive
// - second pin strapped at reset sets enable polarity in backplane mode; hybrid keeps active low
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module tnlc_line_coder
    import tnlc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_bit_i,
    output logic rx_valid_o,
    output logic rx_bit_o,
    output logic line_drive_first_o,
    output logic line_drive_first_oe_o,
    input wire logic line_drive_second_i,
    output logic line_drive_second_o,
    output logic line_drive_second_oe_o,
    output logic transceiver_drive_enable_o,
    input wire logic line_receive_input_i
);
    // ==========================================================
    // register file
    logic [7:0] node_configuration;
    logic [7:0] line_and_clock_setup;
    logic transmitter_enable_bit;
    logic backplane_sel;
    logic first_drive_push_pull_select;
    logic mode_bp;
    logic tx_busy;
    logic enable_active_high;

    assign transmitter_enable_bit = node_configuration[CFG_TRANSMITTER_ENABLE_BIT_BIT];
    assign backplane_sel = node_configuration[CFG_BACKPLANE_BIT];
    assign first_drive_push_pull_select = line_and_clock_setup[SU1_PUSH_PULL_BIT];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            node_configuration <= CONFIG_RESET;
            line_and_clock_setup <= LINE_AND_CLOCK_SETUP_RESET;
        end else if (wr_i) begin
            if (addr_i == OFS_CONFIG) begin
                node_configuration <= wdata_i;
            end
            if (addr_i == OFS_LINE_AND_CLOCK_SETUP) begin
                line_and_clock_setup <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                OFS_CONFIG: rdata_o <= node_configuration;
                OFS_LINE_AND_CLOCK_SETUP: rdata_o <= line_and_clock_setup;
                OFS_STATUS: rdata_o <= {4'h0, enable_active_high, tx_busy, mode_bp, 1'b0};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // polarity strap: second pin sampled after reset release
    logic strap_taken;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strap_taken <= 1'b0;
            enable_active_high <= 1'b0;
        end else if (!strap_taken) begin
            // board grounds the pin for active high; weak pull reads open as high
            strap_taken <= 1'b1;
            enable_active_high <= !line_drive_second_i;
        end
    end

    // ==========================================================
    // transmit fifo and bit timer
    logic fifo_valid;
    logic fifo_bit;
    logic fifo_pop;
    tnlc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_bit_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_bit)
    );

    logic [5:0] bit_cnt;
    logic bit_tick;
    assign bit_tick = (bit_cnt == 6'(BIT_CYC - 1));
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            bit_cnt <= 6'h00;
        end else begin
            bit_cnt <= bit_tick ? 6'h00 : bit_cnt + 6'h01;
        end
    end

    // a bit is taken only at a bit boundary while transmitting
    logic cur_active;
    logic cur_bit;
    assign fifo_pop = bit_tick && transmitter_enable_bit && fifo_valid;
    assign tx_busy = fifo_valid || (bit_cnt != 6'h00 && cur_active);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cur_active <= 1'b0;
            cur_bit <= 1'b0;
        end else if (bit_tick) begin
            cur_active <= fifo_pop;
            cur_bit <= fifo_pop && fifo_bit;
        end
    end

    // mode is latched only between frames so a bit is never coded half and half
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mode_bp <= 1'b0;
        end else if (bit_tick && !cur_active && !fifo_pop) begin
            mode_bp <= backplane_sel;
        end
    end

    // ==========================================================
    // pulse shaping inside the bit cell
    // bit_cnt counts from 0 in the cell after the pop
    logic hyb_p1;
    logic hyb_p2;
    logic bp_p1;
    logic one_now;
    assign one_now = cur_active && cur_bit && !mode_bp;
    // hybrid rate is fixed by the 400ns cell; other rates are not offered
    assign hyb_p1 = one_now && (bit_cnt < 6'(HYB_PULSE_CYC));
    assign hyb_p2 = one_now && (bit_cnt >= 6'(HYB_PULSE_CYC)) &&
                    (bit_cnt < 6'(2 * HYB_PULSE_CYC));
    assign bp_p1 = cur_active && cur_bit && mode_bp &&
                   (bit_cnt < 6'(BP_PULSE_CYC));

    logic xcvr_on;
    logic next_drive_first;
    logic next_drive_first_oe;
    logic next_drive_second;
    logic next_drive_second_oe;
    always_comb begin
        xcvr_on = mode_bp && cur_active;
        next_drive_first = 1'b1;
        next_drive_first_oe = 1'b0;
        next_drive_second = 1'b1;
        next_drive_second_oe = 1'b0;
        if (!mode_bp) begin
            next_drive_first = !hyb_p1;
            next_drive_second = !hyb_p2;
            next_drive_first_oe = 1'b1;
            next_drive_second_oe = 1'b1;
        end else begin
            next_drive_first = !(bp_p1 && xcvr_on);
            // open drain only pulls low; push-pull also drives high
            next_drive_first_oe = first_drive_push_pull_select ? 1'b1 : !next_drive_first;
            // second pin doubles as strap, so it stays released until sampled
            next_drive_second = (bit_cnt < 6'(BIT_CYC / 2));
            next_drive_second_oe = strap_taken;
        end
    end

    tnlc_line_out_t line_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            line_q <= '{drive_first: 1'b1, drive_first_oe: 1'b0, drive_second: 1'b1,
                        drive_second_oe: 1'b0, xcvr_enable: 1'b0};
        end else begin
            line_q.drive_first <= next_drive_first;
            line_q.drive_first_oe <= next_drive_first_oe;
            line_q.drive_second <= next_drive_second;
            line_q.drive_second_oe <= next_drive_second_oe;
            line_q.xcvr_enable <= xcvr_on;
        end
    end

    assign line_drive_first_o = line_q.drive_first;
    assign line_drive_first_oe_o = line_q.drive_first_oe;
    assign line_drive_second_o = line_q.drive_second;
    assign line_drive_second_oe_o = line_q.drive_second_oe;
    // polarity strap applies in backplane mode; hybrid keeps active low
    assign transceiver_drive_enable_o = (mode_bp && enable_active_high) ?
                                        line_q.xcvr_enable : !line_q.xcvr_enable;

    // ==========================================================
    // receive: synchronise, detect pulse, slice to bit cells
    logic [2:0] rx_sync;
    logic rx_level;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_sync <= 3'h0;
            rx_level <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[1:0], line_receive_input_i};
            if (rx_sync[2] == rx_sync[1]) begin
                rx_level <= rx_sync[1];
            end
        end
    end

    logic rx_active;
    logic rx_prev;
    logic rx_start;
    // hybrid pulses are positive, backplane pulses negative
    assign rx_active = mode_bp ? !rx_level : rx_level;
    assign rx_start = rx_active && !rx_prev;

    // the first pulse fixes a grid with the nominal pulse in mid cell, so a pulse
    // shifted by up to a quarter cell either way still lands in its own cell;
    // no realignment, as that would push a later early pulse out of its window
    logic [5:0] rx_cnt;
    logic rx_seen;
    logic rx_run;
    logic mode_bp_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rx_prev <= 1'b0;
            rx_cnt <= 6'h00;
            rx_seen <= 1'b0;
            rx_run <= 1'b0;
            mode_bp_q <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_bit_o <= 1'b0;
        end else begin
            rx_prev <= rx_active;
            mode_bp_q <= mode_bp;
            rx_valid_o <= 1'b0;
            if (mode_bp != mode_bp_q) begin
                // a coding change flips the pulse polarity; restart the receiver
                rx_run <= 1'b0;
                rx_seen <= 1'b0;
            end else if (rx_run) begin
                if (rx_cnt == 6'(BIT_CYC - 1)) begin
                    rx_valid_o <= 1'b1;
                    rx_bit_o <= rx_seen || rx_start;
                    rx_seen <= 1'b0;
                    rx_cnt <= 6'h00;
                end else begin
                    rx_cnt <= rx_cnt + 6'h01;
                    if (rx_start) begin
                        rx_seen <= 1'b1;
                    end
                end
            end else if (rx_start) begin
                rx_run <= 1'b1;
                rx_seen <= 1'b1;
                rx_cnt <= 6'(BIT_CYC / 2);
            end
        end
    end
endmodule

/* File: tnlc_pkg.sv */
// package for the media line coder: register map, field positions, timing counts
// assumes a 50 MHz system clock
package tnlc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int RATE_KBPS = 2500;
    localparam int BIT_NS = 400;
    localparam int HYB_PULSE_NS = 100;
    localparam int BP_PULSE_NS = 200;
    localparam int JITTER_NS = 100;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    localparam int HYB_PULSE_CYC = (HYB_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BP_PULSE_CYC = (BP_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int JITTER_CYC = JITTER_NS / CLK_NS;
    localparam logic [3:0] OFS_CONFIG = 4'h6;
    localparam logic [3:0] OFS_LINE_AND_CLOCK_SETUP = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam int CFG_TRANSMITTER_ENABLE_BIT_BIT = 5;
    localparam int CFG_BACKPLANE_BIT = 2;
    localparam int SU1_PUSH_PULL_BIT = 7;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] LINE_AND_CLOCK_SETUP_RESET = 8'h00;

    typedef struct packed {
        logic drive_first;
        logic drive_first_oe;
        logic drive_second;
        logic drive_second_oe;
        logic xcvr_enable;
    } tnlc_line_out_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_P1 = 2'b01,
        TX_GAP = 2'b10,
        TX_P2 = 2'b11
    } tnlc_tx_state_t;
endpackage

/* File: tnlc_fifo.sv */
// small synchronous fifo, flip-flop storage
// assumes one clock; push and pop are valid/ready handshakes
`timescale 1ns/1ns
module tnlc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: tnlc_monitor.sv */
// checker on the coder ports: pulse shapes, drive style, enable, registers
// assumes a bind into tnlc_line_coder and a single clock domain
`timescale 1ns/1ns
module tnlc_monitor
    import tnlc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rx_valid_o,
    input wire logic line_drive_first_o,
    input wire logic line_drive_first_oe_o,
    input wire logic line_drive_second_i,
    input wire logic line_drive_second_o,
    input wire logic line_drive_second_oe_o,
    input wire logic transceiver_drive_enable_o
);
    logic [7:0] cfg;
    logic pp, strap_hi, run_q, bp_ok, hy_ok;
    logic [5:0] age;
    // a mode change lands only at a bit tick, so judge it long after the write
    assign bp_ok = cfg[CFG_BACKPLANE_BIT] && age == 6'h3F;
    assign hy_ok = !cfg[CFG_BACKPLANE_BIT] && age == 6'h3F;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge clk_i) begin
        run_q <= reset_n_i;
        if (reset_n_i && !run_q) begin
            strap_hi <= !line_drive_second_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cfg <= CONFIG_RESET;
            pp <= LINE_AND_CLOCK_SETUP_RESET[SU1_PUSH_PULL_BIT];
            age <= 6'h00;
        end else if (wr_i && (addr_i == OFS_CONFIG || addr_i == OFS_LINE_AND_CLOCK_SETUP)) begin
            age <= 6'h00;
            cfg <= (addr_i == OFS_CONFIG) ? wdata_i : cfg;
            pp <= (addr_i == OFS_LINE_AND_CLOCK_SETUP) ? wdata_i[SU1_PUSH_PULL_BIT] : pp;
        end else if (age != 6'h3F) begin
            age <= age + 6'h01;
        end
    end
    // ==========================================
    // line side
    a_reset_idle:
        assert property ($rose(reset_n_i) |-> line_drive_first_o && line_drive_second_o
            && !line_drive_first_oe_o && !line_drive_second_oe_o && !rx_valid_o)
        else $error("drives not idle after reset");
    a_pulse_shape:
        assert property ($fell(line_drive_first_o) |-> (!line_drive_first_o)[*5] ##1
            ((line_drive_first_o && !line_drive_second_o)[*5]
            or ((!line_drive_first_o)[*5] ##1 line_drive_first_o)))
        else $error("first drive pulse has wrong shape");
    a_hyb_order:
        assert property (hy_ok && $fell(line_drive_second_o)
            |-> !$past(line_drive_first_o) && line_drive_first_o)
        else $error("second pulse not right after first");
    a_open_drain:
        assert property (bp_ok && !pp && line_drive_first_o |-> !line_drive_first_oe_o)
        else $error("open drain drives high");
    a_push_pull:
        assert property (bp_ok && pp |-> line_drive_first_oe_o)
        else $error("push pull drive released");
    a_xcvr_gate:
        assert property (bp_ok && !line_drive_first_o
            |-> transceiver_drive_enable_o == strap_hi)
        else $error("pulse without enable");
    a_bit_clock:
        assert property (bp_ok && $fell(line_drive_second_o) |-> (!line_drive_second_o)[*8])
        else $error("bit clock low half too short");
    a_rx_spacing:
        assert property (rx_valid_o |=> (!rx_valid_o)[*8])
        else $error("received bits too close");
    // ==========================================
    // register port
    a_read_cfg:
        assert property (rd_i && addr_i == OFS_CONFIG |=> rdata_o == cfg)
        else $error("config read back wrong");
    a_rdata_idle:
        assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
endmodule
bind tnlc_line_coder tnlc_monitor i_tnlc_monitor (.clk_i, .reset_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .rx_valid_o, .line_drive_first_o, .line_drive_first_oe_o,
    .line_drive_second_i, .line_drive_second_o, .line_drive_second_oe_o,
    .transceiver_drive_enable_o);

/* File: tnlc_line_partner.sv */
// far side of the line: pulled-up backplane wire, hybrid coupler, strap pin
// assumes the coder pins are wired straight to it
`timescale 1ns/1ns
module tnlc_line_partner (
    input wire logic hybrid_i,
    input wire logic strap_gnd_i,
    input wire logic inject_i,
    input wire logic inject_level_i,
    input wire logic first_i,
    input wire logic first_oe_i,
    input wire logic second_i,
    input wire logic second_oe_i,
    output logic receive_o,
    output logic strap_o
);
    logic wire_lvl, dipulse;
    // one pull-up on the media: only a driven low wins
    assign wire_lvl = !(first_oe_i && !first_i);
    // coupler turns either drive pulse into one positive pulse
    assign dipulse = (first_oe_i && !first_i) || (second_oe_i && !second_i);
    assign receive_o = inject_i ? inject_level_i : (hybrid_i ? dipulse : wire_lvl);
    // a grounded strap stays grounded; an open pin floats up
    assign strap_o = strap_gnd_i ? 1'b0 : (second_oe_i ? second_i : 1'b1);
endmodule

/* File: tnlc_line_coder_tb_top.sv */
// testbench: registers, both line codings by loopback, receive tolerance, strap
// assumes the partner model and the checker are compiled before it
`timescale 1ns/1ns
module tnlc_line_coder_tb_top
    import tnlc_pkg::*;
;
    typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} tnlc_row_t;
    localparam logic [3:0] PAT = 4'b1011;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rx_valid_o, rx_bit_o;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic tx_valid_i = 1'b0, tx_bit_i = 1'b0, tx_ready_o, line_drive_second_i;
    logic line_drive_first_o, line_drive_first_oe_o, line_drive_second_o;
    logic line_drive_second_oe_o, transceiver_drive_enable_o, line_receive_input_i;
    logic hyb = 1'b1, gnd = 1'b0, inj = 1'b0, inj_lvl = 1'b0, en_seen, prev;
    int mismatches = 0, checks = 0, falls = 0;
    logic rxq[$];
    tnlc_row_t rows[4] = '{'{OFS_CONFIG, 8'h24, 8'h24}, '{OFS_LINE_AND_CLOCK_SETUP, 8'h80, 8'h80},
        '{4'hF, 8'h55, 8'h00}, '{OFS_CONFIG, 8'h00, 8'h00}};
    tnlc_line_coder #(.FIFO_DEPTH(8)) i_tnlc_line_coder (.clk_i, .reset_n_i, .addr_i,
        .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_valid_i, .tx_ready_o, .tx_bit_i, .rx_valid_o,
        .rx_bit_o, .line_drive_first_o, .line_drive_first_oe_o, .line_drive_second_i,
        .line_drive_second_o, .line_drive_second_oe_o, .transceiver_drive_enable_o,
        .line_receive_input_i);
    tnlc_line_partner i_tnlc_line_partner (.hybrid_i(hyb), .strap_gnd_i(gnd),
        .inject_i(inj), .inject_level_i(inj_lvl), .first_i(line_drive_first_o),
        .first_oe_i(line_drive_first_oe_o), .second_i(line_drive_second_o),
        .second_oe_i(line_drive_second_oe_o), .receive_o(line_receive_input_i),
        .strap_o(line_drive_second_i));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        prev <= line_drive_first_o;
        if (rx_valid_o) rxq.push_back(rx_bit_o);
        if (!line_drive_first_o && prev) falls++;
        if (!line_drive_first_o && line_drive_first_oe_o) en_seen <= transceiver_drive_enable_o;
    end
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // ready is read before this edge's updates land, so it is the sampled value
    task automatic push(logic b, output logic ok);
        @(posedge clk_i);
        tx_valid_i <= 1'b1;
        tx_bit_i <= b;
        ok = 1'b0;
        for (int n = 0; n < 30 && !ok; n++) begin
            @(posedge clk_i);
            ok = tx_ready_o;
        end
        tx_valid_i <= 1'b0;
    endtask
    task automatic do_reset(logic strap_low, logic hybrid);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        gnd <= strap_low;
        hyb <= hybrid;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rxq.delete();
    endtask
    task automatic cmp_rx;
        for (int i = 0; i < 4; i++) begin
            check("rx bit", {7'h00, PAT[3 - i]}, {7'h00, rxq[i]});
        end
    endtask
    task automatic run_bits(logic bp, logic pp, logic st);
        logic ok;
        do_reset(st, !bp);
        wr(OFS_LINE_AND_CLOCK_SETUP, {pp, 7'h00});
        wr(OFS_CONFIG, bp ? 8'h24 : 8'h20);
        repeat (60) @(posedge clk_i);
        // cells seen before the coding switch are not part of the pattern
        rxq.delete();
        check("first oe", {7'h00, pp | !bp}, {7'h00, line_drive_first_oe_o});
        falls = 0;
        for (int i = 3; i >= 0; i--) begin
            push(PAT[i], ok);
            check("push", 8'h01, {7'h00, ok});
        end
        repeat (150) @(posedge clk_i);
        check("pulses", 8'h03, 8'(falls));
        cmp_rx();
    endtask
    initial begin
        logic [7:0] d;
        logic ok;
        int n;
        do_reset(1'b0, 1'b1);
        rd(OFS_CONFIG, d);
        check("config reset", CONFIG_RESET, d);
        rd(OFS_LINE_AND_CLOCK_SETUP, d);
        check("setup reset", LINE_AND_CLOCK_SETUP_RESET, d);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            check("register", rows[i].e, d);
        end
        run_bits(1'b0, 1'b0, 1'b0);
        run_bits(1'b1, 1'b0, 1'b0);
        check("enable low", 8'h00, {7'h00, en_seen});
        run_bits(1'b1, 1'b1, 1'b1);
        check("enable high", 8'h01, {7'h00, en_seen});
        // shifted pulses: cell 2 late, cell 3 early, cell 1 empty
        do_reset(1'b0, 1'b1);
        wr(OFS_CONFIG, 8'h00);
        inj <= 1'b1;
        for (n = 0; n < 120; n++) begin
            @(posedge clk_i);
            inj_lvl <= n < 5 || (n >= 44 && n < 49) || (n >= 56 && n < 61);
        end
        inj <= 1'b0;
        cmp_rx();
        // transmitter off keeps bits queued until the buffer refuses
        do_reset(1'b0, 1'b1);
        wr(OFS_CONFIG, 8'h00);
        n = 0;
        ok = 1'b1;
        while (ok && n < 12) begin
            push(1'b0, ok);
            n += int'(ok);
        end
        check("fifo depth", 8'h08, 8'(n));
        falls = 0;
        wr(OFS_CONFIG, 8'h20);
        repeat (220) @(posedge clk_i);
        check("zeros silent", 8'h00, 8'(falls));
        check("drained", 8'h01, {7'h00, tx_ready_o});
        wr(OFS_CONFIG, 8'h24);
        push(1'b1, ok);
        push(1'b1, ok);
        repeat (30) @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 check("reset pins", 8'h15, {3'h0, line_drive_first_o, line_drive_first_oe_o,
            line_drive_second_o, line_drive_second_oe_o, transceiver_drive_enable_o});
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        final_report();
    end
endmodule
